/* File: src/hdr_mem.sv */
// Purpose: Mask and pattern store with byte writes and registered read.
// Assumes: Single clock; contents have no reset.
// Notes: Read data appear the edge after the address.
`default_nettype none

module hdr_mem #(
	parameter int W  = 256,
	parameter int D  = 16,
	parameter int AW = 4
) (
	input  wire logic          aclk,
	input  wire logic          we,
	input  wire logic [AW-1:0] waddr,
	input  wire logic [W/8-1:0] wbe,
	input  wire logic [W-1:0]  wdata,
	input  wire logic [AW-1:0] raddr,
	output logic [W-1:0]       rdata
);
	logic [W-1:0] mem_ff [D];
	logic [W-1:0] rdata_ff;

	always_ff @(posedge aclk) begin
		for (int i = 0; i < W / 8; i++) begin
			if (we && wbe[i])
				mem_ff[waddr][i*8 +: 8] <= wdata[i*8 +: 8];
		end
		rdata_ff <= mem_ff[raddr];
	end

	assign rdata = rdata_ff;
endmodule : hdr_mem

`default_nettype wire

/* File: src/packet_header_classifier.sv */
// Purpose: Classify received frames by masked header patterns.
// Assumes: rx stream is synchronous to aclk; frames are 64 bytes or more.
// Notes: One frame in flight; rx_ready drops from last byte to hand-off.
`default_nettype none

module packet_header_classifier (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [11:0] awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [11:0] araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	input  wire logic        rx_valid,
	output logic             rx_ready,
	input  wire logic [7:0]  rx_data,
	input  wire logic        rx_last,
	input  wire logic        rx_good,
	output logic             res_valid,
	input  wire logic        res_ready,
	output logic             res_hit,
	output logic [1:0]       res_class,
	output logic             res_to_wan,
	output logic [1:0]       res_host_queue,
	output logic [11:0]      res_context_id,
	input  wire logic [3:0]  dma_q_req,
	output logic             dma_grant_valid,
	output logic [1:0]       dma_grant_q
);
	localparam int NC = phc_pkg::N_CLASS;
	typedef enum logic [1:0] {S_RX, S_CMP, S_EVAL, S_PUSH} st_t;
	logic        awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
	logic [1:0]  bresp_ff, rresp_ff;
	logic [31:0] rdata_ff, wdata_ff, ctrl_ff;
	logic [11:0] awaddr_ff;
	logic [3:0]  wstrb_ff;
	logic [31:0] cfg_ff [NC];
	logic [15:0] cd_ff [NC];
	logic [phc_pkg::CNT_W-1:0] hit_cnt_ff, miss_cnt_ff;
	st_t           st_ff, nxt_st;
	phc_pkg::res_t res_ff, nxt_res, ob;
	logic [6:0]  cnt_ff;
	logic [7:0]  byte_d_ff;
	logic [1:0]  lane_d_ff, win, dma_grant_q_ff;
	logic        cmp_v_ff, good_ff, rx_ready_ff, dma_grant_valid_ff;
	logic [NC-1:0] miss_ff, diff_any, hit_vec;
	logic [phc_pkg::MEM_W-1:0]   mem_rd;
	logic [phc_pkg::MEM_W/8-1:0] mem_be;
	logic        beat, in_hdr, any_hit, win_hsel, wr_go, mem_we;
	logic [2:0]  wr_lane;
	logic [31:0] rd_word, status_w;
	stream_if #(.W($bits(phc_pkg::res_t))) q_if ();
	function automatic logic mapped(input logic [11:0] a);
		mapped = (a[1:0] == 2'h0) && (a[11:4] == 8'h00 ||
			a[11:4] == phc_pkg::CFG_OFF[11:4] ||
			a[11:8] == phc_pkg::MASK_OFF[11:8] ||
			a[11:8] == phc_pkg::PAT_OFF[11:8]);
	endfunction : mapped
	function automatic logic [31:0] merge(input logic [31:0] o,
		input logic [31:0] d, input logic [3:0] s);
		for (int i = 0; i < 4; i++)
			merge[i*8 +: 8] = s[i] ? d[i*8 +: 8] : o[i*8 +: 8];
	endfunction : merge
	// ******************************************
	// Register bus
	// ******************************************
	assign awready = awready_ff;
	assign wready  = wready_ff;
	assign bvalid  = bvalid_ff;
	assign bresp   = bresp_ff;
	assign arready = arready_ff;
	assign rvalid  = rvalid_ff;
	assign rdata   = rdata_ff;
	assign rresp   = rresp_ff;
	// Both halves held in flops, then committed in one cycle
	assign wr_go   = !awready_ff && !wready_ff && !bvalid_ff;
	assign mem_we  = wr_go && mapped(awaddr_ff) && awaddr_ff[11:8] != 4'h0;
	assign wr_lane = {awaddr_ff[9], awaddr_ff[7:6]};
	assign mem_be  = 32'(wstrb_ff) << {wr_lane, 2'h0};
	assign status_w = {13'h0, res_ff, st_ff != S_RX};
	// Masks and patterns are write-only and read as zero
	assign rd_word =
		(araddr == phc_pkg::CTRL_OFF)    ? ctrl_ff :
		(araddr == phc_pkg::STATUS_OFF)  ? status_w :
		(araddr == phc_pkg::HITCNT_OFF)  ? {16'h0, hit_cnt_ff} :
		(araddr == phc_pkg::MISSCNT_OFF) ? {16'h0, miss_cnt_ff} :
		(araddr[11:4] == phc_pkg::CFG_OFF[11:4] && araddr[1:0] == 2'h0)
			? cfg_ff[araddr[3:2]] : 32'h0;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_ff <= 1'b1;
			wready_ff  <= 1'b1;
			bvalid_ff  <= 1'b0;
			bresp_ff   <= phc_pkg::RESP_OKAY;
			arready_ff <= 1'b1;
			rvalid_ff  <= 1'b0;
			rdata_ff   <= 32'h0;
			rresp_ff   <= phc_pkg::RESP_OKAY;
		end else begin
			if (awvalid && awready_ff) begin
				awready_ff <= 1'b0;
				awaddr_ff  <= awaddr;
			end
			if (wvalid && wready_ff) begin
				wready_ff <= 1'b0;
				wdata_ff  <= wdata;
				wstrb_ff  <= wstrb;
			end
			if (wr_go) begin
				bvalid_ff <= 1'b1;
				bresp_ff  <= mapped(awaddr_ff) ? phc_pkg::RESP_OKAY
					: phc_pkg::RESP_SLVERR;
			end
			if (bvalid_ff && bready) begin
				bvalid_ff  <= 1'b0;
				awready_ff <= 1'b1;
				wready_ff  <= 1'b1;
			end
			if (arvalid && arready_ff) begin
				arready_ff <= 1'b0;
				rvalid_ff  <= 1'b1;
				rdata_ff   <= mapped(araddr) ? rd_word : 32'h0;
				rresp_ff   <= mapped(araddr) ? phc_pkg::RESP_OKAY
					: phc_pkg::RESP_SLVERR;
			end
			if (rvalid_ff && rready) begin
				rvalid_ff  <= 1'b0;
				arready_ff <= 1'b1;
			end
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_ff <= phc_pkg::CTRL_RST;
			for (int c = 0; c < NC; c++)
				cfg_ff[c] <= phc_pkg::CFG_RST;
		end else if (wr_go) begin
			if (awaddr_ff == phc_pkg::CTRL_OFF)
				ctrl_ff <= merge(ctrl_ff, wdata_ff, wstrb_ff)
					& phc_pkg::CTRL_WMASK;
			for (int c = 0; c < NC; c++)
				if (awaddr_ff == phc_pkg::CFG_OFF + 12'(4 * c))
					cfg_ff[c] <= merge(cfg_ff[c], wdata_ff, wstrb_ff)
						& phc_pkg::CFG_WMASK;
		end
	end
	hdr_mem #(
		.W  (phc_pkg::MEM_W),
		.D  (phc_pkg::MEM_WORDS),
		.AW (4)
	) u_mem (
		.aclk  (aclk),
		.we    (mem_we),
		.waddr (awaddr_ff[5:2]),
		.wbe   (mem_be),
		.wdata ({8{wdata_ff}}),
		.raddr (cnt_ff[5:2]),
		.rdata (mem_rd)
	);
	// ******************************************
	// Header compare and descriptor capture
	// ******************************************
	assign beat   = rx_valid && rx_ready_ff;
	assign in_hdr = !cnt_ff[6];
	for (genvar c = 0; c < NC; c++) begin : g_cls
		logic [7:0] mask_b, pat_b;
		logic [6:0] ofs;
		assign mask_b = mem_rd[c*32 + 8*lane_d_ff +: 8];
		assign pat_b  = mem_rd[128 + c*32 + 8*lane_d_ff +: 8];
		assign diff_any[c] = |((byte_d_ff ^ pat_b) & mask_b);
		assign ofs = {1'b0, cfg_ff[c][phc_pkg::CFG_OFS_LSB +: 6]};
		assign hit_vec[c] = ctrl_ff[phc_pkg::CTRL_EN_BIT]
			&& cfg_ff[c][phc_pkg::CFG_EN_BIT] && !miss_ff[c];
		// Every class grabs its own descriptor; the winner is known late
		always_ff @(posedge aclk) begin
			if (beat && cnt_ff == ofs)
				cd_ff[c][15:8] <= rx_data;
			if (beat && cnt_ff == 7'(ofs + 7'h1))
				cd_ff[c][7:0] <= rx_data;
		end
	end
	// ******************************************
	// Decision and hand-off
	// ******************************************
	assign any_hit  = |hit_vec;
	assign win      = hit_vec[0] ? 2'h0 : hit_vec[1] ? 2'h1 :
		hit_vec[2] ? 2'h2 : 2'h3;
	assign win_hsel = cfg_ff[win][phc_pkg::CFG_HSEL_BIT];
	assign nxt_res.hit    = any_hit;
	assign nxt_res.cls    = any_hit ? win : 2'h0;
	assign nxt_res.to_wan = any_hit && !win_hsel;
	assign nxt_res.queue  = (any_hit && win_hsel)
		? cfg_ff[win][phc_pkg::CFG_PRI_LSB +: 2] : 2'h0;
	assign nxt_res.ctx    = (any_hit && !win_hsel)
		? cd_ff[win][phc_pkg::CTX_W-1:0] : 12'h0;
	always_comb begin
		case (st_ff)
			S_RX:    nxt_st = (beat && rx_last) ? S_CMP : S_RX;
			S_CMP:   nxt_st = S_EVAL;
			S_EVAL:  nxt_st = good_ff ? S_PUSH : S_RX;
			S_PUSH:  nxt_st = q_if.ready ? S_RX : S_PUSH;
			default: nxt_st = S_RX;
		endcase
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_ff       <= S_RX;
			rx_ready_ff <= 1'b0;
			cnt_ff      <= 7'h0;
			cmp_v_ff    <= 1'b0;
			miss_ff     <= '0;
			good_ff     <= 1'b0;
			res_ff      <= '0;
		end else begin
			st_ff       <= nxt_st;
			rx_ready_ff <= nxt_st == S_RX;
			cmp_v_ff    <= beat && in_hdr;
			if (beat) begin
				byte_d_ff <= rx_data;
				lane_d_ff <= cnt_ff[1:0];
				if (in_hdr)
					cnt_ff <= cnt_ff + 7'h1;
			end
			if (beat && rx_last)
				good_ff <= rx_good;
			if (cmp_v_ff)
				miss_ff <= miss_ff | diff_any;
			if (st_ff == S_EVAL) begin
				cnt_ff  <= 7'h0;
				miss_ff <= '0;
				res_ff  <= nxt_res;
			end
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hit_cnt_ff  <= '0;
			miss_cnt_ff <= '0;
		end else if (st_ff == S_EVAL && good_ff) begin
			if (any_hit)
				hit_cnt_ff <= hit_cnt_ff + 16'h1;
			else
				miss_cnt_ff <= miss_cnt_ff + 16'h1;
		end
	end
	assign q_if.valid = st_ff == S_PUSH;
	assign q_if.data  = res_ff;
	res_skid #(.W($bits(phc_pkg::res_t))) u_skid (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.in_s      (q_if),
		.out_valid (res_valid),
		.out_ready (res_ready),
		.out_data  (ob)
	);
	assign res_hit        = ob.hit;
	assign res_class      = ob.cls;
	assign res_to_wan     = ob.to_wan;
	assign res_host_queue = ob.queue;
	assign res_context_id = ob.ctx;
	assign rx_ready       = rx_ready_ff;
	// ******************************************
	// Host DMA queue service order
	// ******************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dma_grant_valid_ff <= 1'b0;
			dma_grant_q_ff     <= 2'h0;
		end else begin
			dma_grant_valid_ff <= |dma_q_req;
			dma_grant_q_ff     <= dma_q_req[3] ? 2'h3 : dma_q_req[2] ? 2'h2
				: dma_q_req[1] ? 2'h1 : 2'h0;
		end
	end
	assign dma_grant_valid = dma_grant_valid_ff;
	assign dma_grant_q     = dma_grant_q_ff;
	// ******************************************
	// Checks
	// ******************************************
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_bad_frame_drop: assert property (
		beat && rx_last && !rx_good |-> !q_if.valid [*4] ##0 st_ff == S_RX)
		else $error("bad frame produced a result");
	a_mask_miss: assert property (
		cmp_v_ff && diff_any[0] |=> miss_ff[0] && !hit_vec[0])
		else $error("unmasked mismatch did not kill class 0");
	a_lowest_class: assert property (
		st_ff == S_EVAL && hit_vec[0] |=> res_ff.hit && res_ff.cls == 2'h0)
		else $error("class 0 hit but not chosen");
	a_unmatched_q0: assert property (
		q_if.valid && !res_ff.hit |-> res_ff.queue == 2'h0 && !res_ff.to_wan)
		else $error("unmatched frame not sent to host queue 0");
	a_host_queue: assert property (
		st_ff == S_EVAL && any_hit && win_hsel |=> !res_ff.to_wan &&
		res_ff.queue == $past(cfg_ff[win][phc_pkg::CFG_PRI_LSB +: 2]))
		else $error("host class queue mismatch");
	a_wan_ctx: assert property (
		st_ff == S_EVAL && any_hit && !win_hsel |=> res_ff.to_wan &&
		res_ff.ctx == $past(cd_ff[win][11:0]))
		else $error("WAN context id mismatch");
	a_cd_capture: assert property (
		beat && cnt_ff == g_cls[1].ofs |=> cd_ff[1][15:8] == $past(rx_data))
		else $error("descriptor high byte not captured");
	a_dma_priority: assert property (
		dma_q_req[3] || dma_q_req == 4'h3 |=> dma_grant_valid_ff &&
		dma_grant_q_ff == ($past(dma_q_req[3]) ? 2'h3 : 2'h1))
		else $error("DMA queue priority violated");
	a_push_hold: assert property (
		st_ff == S_EVAL && good_ff |=> q_if.valid)
		else $error("result not offered after evaluation");
	a_push_stable: assert property (
		q_if.valid && !q_if.ready |=> q_if.valid && $stable(q_if.data))
		else $error("offered result dropped or changed");
	a_read_answer: assert property (
		arvalid && arready_ff |=> rvalid_ff && !arready_ff)
		else $error("read answer late");
	cover property (q_if.valid && q_if.ready && res_ff.to_wan);
	cover property (q_if.valid && q_if.ready && res_ff.hit && !res_ff.to_wan);
	cover property (q_if.valid && q_if.ready && !res_ff.hit);
	cover property (q_if.valid && !q_if.ready);
endmodule : packet_header_classifier
`default_nettype wire

/* File: src/phc_pkg.sv */
// Purpose: Constants and types of the packet header classifier.
// Assumes: 40 MHz aclk, AXI4-Lite register access, byte-wide rx stream.
// Notes: Mask bit 1 = compare the bit; mask bit 0 = ignore it.
`default_nettype none

package phc_pkg;
	localparam int N_CLASS   = 4;
	localparam int HDR_BYTES = 64;
	localparam int MEM_WORDS = HDR_BYTES / 4;
	localparam int MEM_W     = 2 * N_CLASS * 32;
	localparam int CTX_W     = 12;
	localparam int CNT_W     = 16;
	localparam int AXI_AW    = 12;

	localparam logic [11:0] CTRL_OFF    = 12'h000;
	localparam logic [11:0] STATUS_OFF  = 12'h004;
	localparam logic [11:0] HITCNT_OFF  = 12'h008;
	localparam logic [11:0] MISSCNT_OFF = 12'h00c;
	localparam logic [11:0] CFG_OFF     = 12'h010;
	localparam logic [11:0] MASK_OFF    = 12'h100;
	localparam logic [11:0] PAT_OFF     = 12'h200;

	localparam int          CTRL_EN_BIT = 0;
	localparam logic [31:0] CTRL_RST    = 32'h0000_0001;
	localparam logic [31:0] CTRL_WMASK  = 32'h0000_0001;

	localparam int          CFG_OFS_LSB  = 0;
	localparam int          CFG_OFS_W    = 6;
	localparam int          CFG_HSEL_BIT = 8;
	localparam int          CFG_PRI_LSB  = 9;
	localparam int          CFG_EN_BIT   = 12;
	localparam logic [31:0] CFG_RST      = 32'h0000_0000;
	localparam logic [31:0] CFG_WMASK    = 32'h0000_173f;

	localparam int ST_BUSY_BIT = 0;
	localparam int ST_RES_LSB  = 1;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic [CTX_W-1:0] ctx;
		logic [1:0]       queue;
		logic             to_wan;
		logic [1:0]       cls;
		logic             hit;
	} res_t;
endpackage : phc_pkg

`default_nettype wire

/* File: src/res_skid.sv */
// Purpose: Two-entry result buffer between classifier and queue manager.
// Assumes: Source keeps valid and data until taken.
// Notes: Output valid and data come from flip-flops.
`default_nettype none

module res_skid #(parameter int W = 18) (
	input  wire logic  aclk,
	input  wire logic  aresetn,
	stream_if.snk      in_s,
	output logic       out_valid,
	input  wire logic  out_ready,
	output logic [W-1:0] out_data
);
	logic         vld_ff;
	logic         sk_vld_ff;
	logic [W-1:0] data_ff;
	logic [W-1:0] sk_data_ff;
	logic         in_hs;

	// Ready only from a flop, so no path from out_ready back upstream
	assign in_s.ready = !sk_vld_ff;
	assign in_hs      = in_s.valid && !sk_vld_ff;
	assign out_valid  = vld_ff;
	assign out_data   = data_ff;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			vld_ff    <= 1'b0;
			sk_vld_ff <= 1'b0;
		end else if (!vld_ff || out_ready) begin
			vld_ff    <= sk_vld_ff || in_hs;
			sk_vld_ff <= 1'b0;
			data_ff   <= sk_vld_ff ? sk_data_ff : in_s.data;
		end else if (in_hs) begin
			sk_vld_ff  <= 1'b1;
			sk_data_ff <= in_s.data;
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_skid_hold: assert property (
		out_valid && !out_ready |=> out_valid && $stable(out_data))
		else $error("result dropped or changed while stalled");
	cover property (out_valid && !out_ready && sk_vld_ff);
endmodule : res_skid

`default_nettype wire

/* File: src/stream_if.sv */
// Purpose: Valid/ready word carrier between classifier stages.
// Assumes: One clock; a word moves when valid and ready are both high.
// Notes: Source holds valid and data until taken.
`default_nettype none

interface stream_if #(parameter int W = 8) ();
	logic         valid;
	logic         ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : stream_if

`default_nettype wire

/* File: testbench/phc_partner.sv */
// Purpose: Receive MAC source and queue manager sink for the classifier.
// Assumes: Calls to send start just after a rising edge of aclk.
// Notes: Idle data line shows the inverse of the last byte sent.
`default_nettype none

module phc_partner (
	input  wire logic  aclk,
	input  wire logic  rx_ready,
	output logic       rx_valid,
	output logic [7:0] rx_data,
	output logic       rx_last,
	output logic       rx_good,
	output logic       res_ready,
	input  wire logic  stall,
	output logic       hung
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0]  fr [72];
	logic [31:0] lf;

	function automatic logic [31:0] xs(input logic [31:0] v);
		logic [31:0] s;
		s = v ^ (v << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction : xs

	initial begin
		{rx_valid, rx_data, rx_last, rx_good, res_ready, hung} = '0;
		lf = 32'h0001_7b17;
	end

	// *************************************
	// Sink: stalls at random on request
	// *************************************
	always @(posedge aclk) begin
		lf <= xs(lf);
		res_ready <= stall ? lf[4] : 1'b1;
	end

	// Frame bytes held until taken; frame holds its descriptor
	task automatic send(input int n, input logic good);
		logic t;
		// One edge apart, so a release and a new frame never collide
		@(posedge aclk);
		for (int i = 0; i < n; i++) begin
			rx_valid <= 1'b1;
			rx_data  <= fr[i];
			rx_last  <= (i == n - 1);
			rx_good  <= good;
			t = 1'b0;
			for (int k = 0; k < 400 && !t; k++) begin
				@(negedge aclk);
				t = rx_ready;
				@(posedge aclk);
			end
			if (!t) hung <= 1'b1;
		end
		rx_valid <= 1'b0;
		rx_last  <= 1'b0;
		rx_data  <= ~fr[n-1];
	endtask : send
endmodule : phc_partner

`default_nettype wire

/* File: testbench/testbench.sv */
// Purpose: Self-checking bench of the packet header classifier.
// Assumes: Four classes keyed on header byte 12.
// Notes: Results are compared in order against a queue of expectations.
`default_nettype none

module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid;
	logic        bready, arvalid, arready, rvalid, rready, rx_valid;
	logic        rx_ready, rx_last, rx_good, res_valid, res_ready, res_hit;
	logic        res_to_wan, dma_grant_valid, stall, hung, dgo;
	logic [11:0] awaddr, araddr, res_context_id;
	logic [31:0] wdata, rdata, seed;
	logic [1:0]  bresp, rresp, res_class, res_host_queue, dma_grant_q;
	logic [3:0]  wstrb, dma_q_req, dseen;
	logic [7:0]  rx_data;
	logic [7:0]  mk [4] = '{8'hff, 8'hff, 8'hff, 8'hf0};
	logic [7:0]  pt [4] = '{8'h10, 8'h11, 8'h12, 8'h10};
	logic [5:0]  ofs [4] = '{6'h12, 6'h3e, 6'h05, 6'h01};
	logic        hsel [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
	logic [1:0]  hq [4] = '{2'h3, 2'h0, 2'h2, 2'h1};
	logic        ctrl_on = 1'b1;
	int          err_count = 0, samples_checked = 0, hits = 0, miss = 0;
	phc_pkg::res_t expq [$];
	localparam logic [1:0] OK = phc_pkg::RESP_OKAY;
	localparam logic [1:0] SE = phc_pkg::RESP_SLVERR;

	packet_header_classifier uut (.aclk, .aresetn, .awaddr, .awvalid,
		.awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
		.araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
		.rx_valid, .rx_ready, .rx_data, .rx_last, .rx_good, .res_valid,
		.res_ready, .res_hit, .res_class, .res_to_wan, .res_host_queue,
		.res_context_id, .dma_q_req, .dma_grant_valid, .dma_grant_q);
	phc_partner p (.aclk, .rx_ready, .rx_valid, .rx_data, .rx_last,
		.rx_good, .res_ready, .stall, .hung);

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd

	task automatic check(input logic [31:0] seen, input logic [31:0] exp,
		input string m);
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value at %0t: %s %h not %h", $time, m, seen, exp);
		end
	endtask : check

	task automatic close_out();
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : close_out

	task automatic timeout();
		err_count++;
		$display("wrong value at %0t: wait ran out", $time);
		close_out();
	endtask : timeout

	// *************************************
	// Register bus master
	// *************************************
	task automatic axw(input logic [11:0] a, input logic [31:0] d,
		input logic [1:0] er);
		logic aw, w, b;
		@(posedge aclk);
		{awaddr, wdata, wstrb} <= {a, d, 4'hf};
		{awvalid, wvalid, bready} <= 3'h7;
		b = 1'b0;
		for (int k = 0; k < 100 && !b; k++) begin
			@(negedge aclk);
			{aw, w, b} = {awready, wready, bvalid};
			if (b) check(bresp, er, "bresp");
			@(posedge aclk);
			if (aw) awvalid <= 1'b0;
			if (w) wvalid <= 1'b0;
			if (b) bready <= 1'b0;
		end
		if (!b) timeout();
	endtask : axw

	task automatic axr(input logic [11:0] a, input logic [31:0] ed,
		input logic [1:0] er);
		logic ar, r;
		@(posedge aclk);
		araddr <= a;
		{arvalid, rready} <= 2'h3;
		r = 1'b0;
		for (int k = 0; k < 100 && !r; k++) begin
			@(negedge aclk);
			{ar, r} = {arready, rvalid};
			if (r) check(rdata, ed, "rdata");
			if (r) check(rresp, er, "rresp");
			@(posedge aclk);
			if (ar) arvalid <= 1'b0;
			if (r) rready <= 1'b0;
		end
		if (!r) timeout();
	endtask : axr

	function automatic logic [31:0] cfgw(input int c);
		return {19'h0, 1'b1, 1'b0, hq[c], hsel[c], 2'h0, ofs[c]};
	endfunction : cfgw

	// Reference classification of one frame, then send it
	task automatic frame(input logic [7:0] ty, input logic good);
		phc_pkg::res_t e;
		logic [15:0]   cd;
		for (int i = 0; i < 72; i++) p.fr[i] = 8'(rnd());
		p.fr[12] = ty;
		e = '0;
		for (int c = 3; c >= 0; c--) begin
			cd = {p.fr[ofs[c]], p.fr[ofs[c] + 1]};
			if (ctrl_on && ((ty ^ pt[c]) & mk[c]) == 8'h00) begin
				e.hit    = 1'b1;
				e.cls    = 2'(c);
				e.to_wan = !hsel[c];
				e.queue  = hsel[c] ? hq[c] : 2'h0;
				e.ctx    = hsel[c] ? 12'h000 : cd[11:0];
			end
		end
		if (good) expq.push_back(e);
		if (good && e.hit) hits++;
		if (good && !e.hit) miss++;
		p.send(64 + int'(rnd() % 8), good);
	endtask : frame

	initial begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end

	// *************************************
	// Result and grant watchers
	// *************************************
	always @(posedge aclk) begin
		dseen <= dma_q_req;
		dgo <= aresetn;
		dma_q_req <= 4'(rnd());
	end

	always @(negedge aclk) begin
		if (hung) timeout();
		if (aresetn && res_valid && res_ready) begin
			if (expq.size() == 0) check(1, 0, "extra result");
			else check({res_context_id, res_host_queue, res_to_wan, res_class,
				res_hit}, expq.pop_front(), "result");
		end
		if (dgo) check(dma_grant_valid, |dseen, "grant");
		if (dgo && |dseen) check(dma_grant_q, dseen[3] ? 3 : dseen[2] ? 2 :
			dseen[1] ? 1 : 0, "grant queue");
	end

	// *************************************
	// Main sequence
	// *************************************
	initial begin
		seed = 32'h0001_7b17;
		aresetn = 1'b0;
		{awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
		{araddr, arvalid, rready, stall} = '0;
		repeat (6) @(posedge aclk);
		@(negedge aclk);
		check({rx_ready, res_valid}, 0, "reset outputs");
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		axr(phc_pkg::CTRL_OFF, phc_pkg::CTRL_RST, OK);
		axr(phc_pkg::STATUS_OFF, 0, OK);
		axr(phc_pkg::CFG_OFF, phc_pkg::CFG_RST, OK);
		axr(12'h080, 0, SE);
		axw(12'h080, 32'hffff_ffff, SE);
		axw(phc_pkg::CFG_OFF, 32'hffff_ffff, OK);
		axr(phc_pkg::CFG_OFF, phc_pkg::CFG_WMASK, OK);
		axr(phc_pkg::MASK_OFF, 0, OK);
		$display("test registers done");
		for (int c = 0; c < 4; c++) begin
			for (int w = 0; w < 16; w++) begin
				axw(phc_pkg::MASK_OFF + 12'(64 * c + 4 * w),
					(w == 3) ? {24'h0, mk[c]} : 32'h0, OK);
				axw(phc_pkg::PAT_OFF + 12'(64 * c + 4 * w), (w == 3) ?
					(rnd() & 32'hffff_ff00) | pt[c] : rnd(), OK);
			end
			axw(phc_pkg::CFG_OFF + 12'(4 * c), cfgw(c), OK);
		end
		foreach (pt[i]) frame(pt[i], 1'b1);
		frame(8'h13, 1'b1);
		frame(8'h12, 1'b1);
		frame(8'h27, 1'b1);
		for (int q = 0; q < 4; q++) begin
			hq[3] = 2'(q);
			axw(phc_pkg::CFG_OFF + 12'hc, cfgw(3), OK);
			frame(8'h1e, 1'b1);
		end
		$display("test routing done");
		frame(8'h10, 1'b0);
		frame(8'h11, 1'b1);
		axw(phc_pkg::CTRL_OFF, 32'h0, OK);
		ctrl_on = 1'b0;
		frame(8'h10, 1'b1);
		axw(phc_pkg::CTRL_OFF, 32'h1, OK);
		ctrl_on = 1'b1;
		$display("test refusal done");
		stall <= 1'b1;
		for (int i = 0; i < 12; i++) frame(8'h0e + 8'(rnd() % 7), 1'b1);
		stall <= 1'b0;
		for (int k = 0; k < 2000 && expq.size() > 0; k++) @(posedge aclk);
		if (expq.size() > 0) timeout();
		axr(phc_pkg::HITCNT_OFF, 32'(hits), OK);
		axr(phc_pkg::MISSCNT_OFF, 32'(miss), OK);
		$display("test stall done");
		close_out();
	end
endmodule : testbench

`default_nettype wire
